//--- logic/efc_defines.vh
`ifndef EFC_DEFINES_VH
`define EFC_DEFINES_VH
// register indices, byte address is index times four
`define EFC_IDX_POLARITY 8'hbf
`define EFC_IDX_A_CLR 8'hc2
`define EFC_IDX_B_CLR 8'hc6
`define EFC_IDX_C_CLR 8'hca
`define EFC_IDX_ENABLES 8'hd0
`define EFC_IDX_A_SET 8'hd1
`define EFC_IDX_B_SET 8'hd2
`define EFC_IDX_C_SET 8'hd3
`define EFC_IDX_STATUS 8'hd4
`define EFC_IDX_PINSEL 8'hd5
// enable fields
`define EFC_EN_TX_A 0
`define EFC_EN_RX_A 1
`define EFC_EN_TX_B 2
`define EFC_EN_RX_B 3
`define EFC_EN_TX_C 4
`define EFC_EN_RX_C 5
// reset values
`define EFC_ENABLES_RST 6'h00
`define EFC_POLARITY_RST 3'h0
`define EFC_DELAY_RST 16'h0001
`define EFC_PINSEL_RST 12'h000
// timing
`define EFC_CLK_HZ 40000000
`define EFC_STEP_NS 1000
`define EFC_CLK_NS 25
`define EFC_STEP_CYC (`EFC_STEP_NS / `EFC_CLK_NS)
`define EFC_NUM_PINS 13
`endif

//--- logic/efc_sequencer.v
// Function
// RULE1: tx enable A: assert after set delay
// RULE2: tx enable A: release after clear delay
// RULE3: rx enable A: follow receive immediately
// RULE4: tx enable B: assert after set delay
// RULE5: tx enable B: release after clear delay
// RULE6: rx enable B: follow receive immediately
// RULE7: tx enable C: assert after set delay
// RULE8: tx enable C: release after clear delay
// RULE9: rx enable C: follow receive immediately
// RULE10: six enable bits, reset zero
// RULE11: three invert bits, one per line
// RULE12: six 16-bit microsecond delays, reset one
// RULE13: software writes polarity upper bits zero
// RULE14: each line routable to one of 13 pins
// RULE15: both enables clear holds line inactive
// RULE16: inversion applied last
`timescale 1ns/1ps
`default_nettype none
`include "efc_defines.vh"
module efc_sequencer #(
  parameter NUM_PINS = `EFC_NUM_PINS
) (
  input wire clk_sys,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire tx_trigger,
  input wire tx_done,
  input wire rx_trigger,
  input wire rx_done,
  output reg [NUM_PINS-1:0] gpio_out,
  output reg [NUM_PINS-1:0] gpio_oe
);
  // ahb data phase capture
  reg wr_pend_r;
  reg [7:0] wr_idx_r;
  wire [7:0] idx;
  wire take;
  reg [5:0] enables_r;
  reg [2:0] polarity_r;
  reg [15:0] set_dly_r [0:2];
  reg [15:0] clr_dly_r [0:2];
  reg [11:0] pinsel_r;
  reg [2:0] line_r;
  reg [31:0] rd_nxt;
  reg tx_trig_s1_r;
  reg tx_trig_s2_r;
  reg tx_done_s1_r;
  reg tx_done_s2_r;
  reg rx_trig_s1_r;
  reg rx_trig_s2_r;
  reg rx_done_s1_r;
  reg rx_done_s2_r;
  reg tx_trig_d_r;
  reg tx_done_d_r;
  reg rx_trig_d_r;
  reg rx_done_d_r;
  wire tx_trig_p;
  wire tx_done_p;
  wire rx_trig_p;
  wire rx_done_p;
  reg [5:0] us_cnt_r;
  wire us_tick;
  integer i;
  integer j;
  localparam integer step_last = `EFC_STEP_CYC - 1;
  function [3:0] pin_of;
    input [11:0] sel;
    input [1:0] ln;
    begin
      case (ln)
        2'd0: pin_of = sel[3:0];
        2'd1: pin_of = sel[7:4];
        default: pin_of = sel[11:8];
      endcase
    end
  endfunction
  assign idx = haddr[9:2];
  assign take = hsel & hready & htrans[1];
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_r <= take & hwrite;
      wr_idx_r <= idx;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take & ~hwrite)
        hrdata <= rd_nxt;
    end
  end
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (idx)
      `EFC_IDX_ENABLES: rd_nxt = {26'h0000000, enables_r};
      `EFC_IDX_POLARITY: rd_nxt = {29'h00000000, polarity_r};
      `EFC_IDX_A_SET: rd_nxt = {16'h0000, set_dly_r[0]};
      `EFC_IDX_B_SET: rd_nxt = {16'h0000, set_dly_r[1]};
      `EFC_IDX_C_SET: rd_nxt = {16'h0000, set_dly_r[2]};
      `EFC_IDX_A_CLR: rd_nxt = {16'h0000, clr_dly_r[0]};
      `EFC_IDX_B_CLR: rd_nxt = {16'h0000, clr_dly_r[1]};
      `EFC_IDX_C_CLR: rd_nxt = {16'h0000, clr_dly_r[2]};
      `EFC_IDX_STATUS: rd_nxt = {29'h00000000, line_r};
      `EFC_IDX_PINSEL: rd_nxt = {20'h00000, pinsel_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end
  // register writes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      enables_r <= `EFC_ENABLES_RST; // RULE10
      polarity_r <= `EFC_POLARITY_RST;
      pinsel_r <= `EFC_PINSEL_RST;
      for (i = 0; i < 3; i = i + 1)
      begin
        set_dly_r[i] <= `EFC_DELAY_RST; // RULE12
        clr_dly_r[i] <= `EFC_DELAY_RST;
      end
    end
    else if (wr_pend_r)
    begin
      case (wr_idx_r)
        `EFC_IDX_ENABLES: enables_r <= hwdata[5:0]; // RULE10
        `EFC_IDX_POLARITY: polarity_r <= hwdata[2:0]; // RULE11
        `EFC_IDX_A_SET: set_dly_r[0] <= hwdata[15:0]; // RULE12
        `EFC_IDX_B_SET: set_dly_r[1] <= hwdata[15:0];
        `EFC_IDX_C_SET: set_dly_r[2] <= hwdata[15:0];
        `EFC_IDX_A_CLR: clr_dly_r[0] <= hwdata[15:0];
        `EFC_IDX_B_CLR: clr_dly_r[1] <= hwdata[15:0];
        `EFC_IDX_C_CLR: clr_dly_r[2] <= hwdata[15:0];
        `EFC_IDX_PINSEL: pinsel_r <= hwdata[11:0]; // RULE14
        default: ;
      endcase
    end
  end
  // event synchronisers and edge detect
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_trig_s1_r <= 1'b0;
      tx_trig_s2_r <= 1'b0;
      tx_done_s1_r <= 1'b0;
      tx_done_s2_r <= 1'b0;
      rx_trig_s1_r <= 1'b0;
      rx_trig_s2_r <= 1'b0;
      rx_done_s1_r <= 1'b0;
      rx_done_s2_r <= 1'b0;
      tx_trig_d_r <= 1'b0;
      tx_done_d_r <= 1'b0;
      rx_trig_d_r <= 1'b0;
      rx_done_d_r <= 1'b0;
    end
    else
    begin
      tx_trig_s1_r <= tx_trigger;
      tx_trig_s2_r <= tx_trig_s1_r;
      tx_done_s1_r <= tx_done;
      tx_done_s2_r <= tx_done_s1_r;
      rx_trig_s1_r <= rx_trigger;
      rx_trig_s2_r <= rx_trig_s1_r;
      rx_done_s1_r <= rx_done;
      rx_done_s2_r <= rx_done_s1_r;
      tx_trig_d_r <= tx_trig_s2_r;
      tx_done_d_r <= tx_done_s2_r;
      rx_trig_d_r <= rx_trig_s2_r;
      rx_done_d_r <= rx_done_s2_r;
    end
  end
  assign tx_trig_p = tx_trig_s2_r & ~tx_trig_d_r;
  assign tx_done_p = tx_done_s2_r & ~tx_done_d_r;
  assign rx_trig_p = rx_trig_s2_r & ~rx_trig_d_r;
  assign rx_done_p = rx_done_s2_r & ~rx_done_d_r;
  // microsecond prescaler
  always @(posedge clk_sys)
  begin
    if (rst)
      us_cnt_r <= 6'h00;
    else if (us_tick)
      us_cnt_r <= 6'h00;
    else
      us_cnt_r <= us_cnt_r + 6'h01;
  end
  assign us_tick = (us_cnt_r == step_last[5:0]);
  // per-line sequencers
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : seq
      reg tx_act_r;
      reg rx_act_r;
      reg set_pend_r;
      reg clr_pend_r;
      reg [15:0] cnt_r;
      wire tx_en;
      wire rx_en;
      assign tx_en = enables_r[2*g];
      assign rx_en = enables_r[2*g+1];
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          tx_act_r <= 1'b0;
          rx_act_r <= 1'b0;
          set_pend_r <= 1'b0;
          clr_pend_r <= 1'b0;
          cnt_r <= 16'h0000;
        end
        else
        begin
          if (!tx_en)
          begin
            tx_act_r <= 1'b0; // RULE15
            set_pend_r <= 1'b0;
            clr_pend_r <= 1'b0;
          end
          else if (tx_trig_p)
          begin
            set_pend_r <= 1'b1; // RULE1 RULE4 RULE7
            clr_pend_r <= 1'b0;
            cnt_r <= set_dly_r[g];
          end
          else if (tx_done_p)
          begin
            clr_pend_r <= 1'b1; // RULE2 RULE5 RULE8
            set_pend_r <= 1'b0;
            cnt_r <= clr_dly_r[g];
          end
          else if ((set_pend_r | clr_pend_r) && us_tick)
          begin
            if (cnt_r <= 16'h0001)
            begin
              tx_act_r <= set_pend_r; // RULE1 RULE2 RULE4 RULE5 RULE7 RULE8
              set_pend_r <= 1'b0;
              clr_pend_r <= 1'b0;
            end
            else
              cnt_r <= cnt_r - 16'h0001;
          end
          if (!rx_en)
            rx_act_r <= 1'b0; // RULE15
          else if (rx_trig_p)
            rx_act_r <= 1'b1; // RULE3 RULE6 RULE9
          else if (rx_done_p)
            rx_act_r <= 1'b0; // RULE3 RULE6 RULE9
        end
      end
    end
  endgenerate
  // output stage with inversion and pin routing
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      line_r <= 3'h0;
      gpio_out <= {NUM_PINS{1'b0}};
      gpio_oe <= {NUM_PINS{1'b0}};
    end
    else
    begin
      line_r <= {seq[2].tx_act_r | seq[2].rx_act_r,
        seq[1].tx_act_r | seq[1].rx_act_r,
        seq[0].tx_act_r | seq[0].rx_act_r};
      for (j = 0; j < NUM_PINS; j = j + 1)
      begin
        gpio_out[j] <= 1'b0;
        gpio_oe[j] <= 1'b0;
        if (pin_of(pinsel_r, 2'd0) == j[3:0])
        begin
          gpio_out[j] <= line_r[0] ^ polarity_r[0]; // RULE14 RULE16
          gpio_oe[j] <= 1'b1;
        end
        else if (pin_of(pinsel_r, 2'd1) == j[3:0])
        begin
          gpio_out[j] <= line_r[1] ^ polarity_r[1]; // RULE16
          gpio_oe[j] <= 1'b1;
        end
        else if (pin_of(pinsel_r, 2'd2) == j[3:0])
        begin
          gpio_out[j] <= line_r[2] ^ polarity_r[2]; // RULE16
          gpio_oe[j] <= 1'b1;
        end
      end
    end
  end
endmodule // efc_sequencer
`default_nettype wire

//--- verification/efc_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module efc_sequencer_chk #(
  parameter NUM_PINS = 13
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe
);
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  wire logic wr = hsel && hready && htrans[1] && hwrite;
  wire logic [7:0] ix = haddr[9:2];
  logic [2:0] quiet_r;
  // cycles since the last write or reset
  always @(posedge clk_sys)
  begin
    if (rst || wr)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($past(rst) |-> gpio_oe == 0)
    else $error("pins on after reset");
  a_unrouted_low: assert property ((gpio_out & ~gpio_oe) == 0)
    else $error("unrouted pin high");
  a_oe_max_three: assert property ($countones(gpio_oe) <= 3)
    else $error("too many pins");
  a_oe_quiet: assert property (
    quiet_r == 3'h7 |-> $stable(gpio_oe)) else $error("routing moved");
  a_rd_upper: assert property (rd |=> hrdata[31:16] == 0)
    else $error("read upper bits set");
  a_pol_width: assert property (
    rd && ix == 8'hbf |=> hrdata[31:3] == 0) else $error("invert width");
  a_en_width: assert property (
    rd && ix == 8'hd0 |=> hrdata[31:6] == 0) else $error("enable width");
  a_rd_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  cover property (rd);
  cover property ($rose(gpio_out[1]));
  cover property ($fell(gpio_out[1]));
endmodule // efc_sequencer_chk
bind efc_sequencer efc_sequencer_chk #(.NUM_PINS(NUM_PINS)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe));
`default_nettype wire

//--- verification/efc_frontend_model.sv
`timescale 1ns/1ps
`default_nettype none
module efc_frontend_model (
  input wire logic [12:0] gpio_out,
  input wire logic [12:0] gpio_oe,
  output wire logic [12:0] lvl
);
  // undriven pins sit at the pull-down level
  assign lvl = gpio_out & gpio_oe;
endmodule // efc_frontend_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ev_r = 4'h0;
  logic [31:0] rd;
  logic [7:0] ia [9] = '{8'hbf, 8'hc2, 8'hc6, 8'hca, 8'hd0, 8'hd1,
    8'hd2, 8'hd3, 8'h00};
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic [12:0] gpio_out;
  wire logic [12:0] gpio_oe;
  wire logic [12:0] lvl;
  int miscompares = 0;
  int check_count = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  efc_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .tx_trigger(ev_r[0]),
    .tx_done(ev_r[1]), .rx_trigger(ev_r[2]), .rx_done(ev_r[3]),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  efc_frontend_model fe_u (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .lvl(lvl));
  task complete_run(input bit hung);
  begin
    if (hung)
      miscompares++;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
  begin
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // one rising edge with ready high, bounded
  task rdy;
  int t;
  begin
    t = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1 && t < 50)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 50)
      complete_run(1'b1);
  end
  endtask
  task bus(input bit w, input logic [7:0] ix, input logic [31:0] wd);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'h0};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rd = hrdata;
  end
  endtask
  task wpin(input int p, input logic v);
  begin
    n = 0;
    while (lvl[p] !== v && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000)
      complete_run(1'b1);
  end
  endtask
  task t_reset;
  begin
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, ia[i], 32'h0);
      chk(rd, 32'(i % 4 != 0), "reset");
    end
    bus(1'b1, 8'hc2, 32'hffff);
    bus(1'b0, 8'hc2, 32'h0);
    chk(rd, 32'hffff, "delay rw");
    chk(32'(gpio_oe), 32'h1, "reset routing");
    bus(1'b1, 8'hd5, 32'h321);
    bus(1'b0, 8'hd5, 32'h0);
    chk(rd, 32'h321, "pinsel rw");
    repeat (4) @(posedge clk_sys);
    chk(32'(gpio_oe), 32'he, "routing");
    chk(32'(lvl), 32'h0, "idle");
  end
  endtask
  task t_rx(input logic [2:0] pol);
  begin
    bus(1'b1, 8'hbf, {29'h0, pol});
    repeat (4) @(posedge clk_sys);
    chk(32'(lvl[3:1]), 32'(pol), "idle pol");
    bus(1'b1, 8'hd0, 32'h2a);
    for (int k = 2; k < 4; k++)
    begin
      ev_r[k] <= 1'b1;
      wpin(1, pol[0] ^ (k == 2));
      ev_r[k] <= 1'b0;
      chk(32'(n <= 9), 32'h1, "rx time");
      chk(32'(lvl[3:1]), 32'(pol ^ {3{k == 2}}), "rx");
      bus(1'b0, 8'hd4, 32'h0);
      chk(rd, 32'(k == 2 ? 7 : 0), "status");
    end
    ev_r[2] <= 1'b1;
    wpin(1, !pol[0]);
    bus(1'b1, 8'hd0, 32'h0);
    wpin(1, pol[0]);
    ev_r[2] <= 1'b0;
    chk(32'(lvl[3:1]), 32'(pol), "rx disabled");
  end
  endtask
  task t_tx;
  int s;
  bit ok;
  begin
    bus(1'b1, 8'hbf, 32'h0);
    bus(1'b1, 8'hd0, 32'h15);
    for (int i = 1; i < 4; i++)
    begin
      bus(1'b1, 8'(8'hd0 + i), 32'(i + 1));
      bus(1'b1, 8'(8'hbe + 4 * i), 32'(i));
    end
    for (int k = 0; k < 2; k++)
    begin
      ev_r[1:0] <= k ? 2'h2 : 2'h1;
      s = 0;
      for (int i = 1; i < 4; i++)
      begin
        wpin(i, !k);
        s += n;
        ok = s >= (i + !k - 1) * 40 && s <= (i + !k) * 40 + 12;
        chk(32'(ok), 32'h1, "tx delay");
      end
    end
    ev_r[1] <= 1'b0;
  end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_rx(3'h0);
    t_rx(3'h7);
    t_tx;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    complete_run(1'b0);
  end
endmodule // testbench
`default_nettype wire
